// ### dv/ebw_mem_model.sv
// partner model: external memory whose ready output stays low for a set number of selected cycles
`timescale 1ns/1ns
module ebw_mem_model
  import ebw_pkg::*;
(
  // bus side
  input  wire logic              clk_sys_i,
  input  wire logic              zone_select_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic [EBW_AW-1:0] addr_i,
  input  wire logic [EBW_DW-1:0] data_i,
  // bench control
  input  wire logic [7:0]        hold_cycles_i,
  // answers
  output logic      [EBW_DW-1:0] data_o,
  output logic                   ready_o
);
  logic [EBW_DW-1:0] mem [0:15];
  logic [7:0]        sel_cnt;
  initial begin
    sel_cnt = 8'h00;
    ready_o = 1'b0;
    data_o  = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'hA500 + 16'(i);
    end
  end
  always @(posedge clk_sys_i) begin
    sel_cnt <= zone_select_n_i ? 8'h00 : sel_cnt + 8'h01;
    // low while more time is needed, high once the access may finish
    ready_o <= !zone_select_n_i && (sel_cnt + 8'h01 >= hold_cycles_i);
    if (!write_strobe_n_i) begin
      mem[addr_i[3:0]] <= data_i;
    end
    // released bus toggles to the inverse every cycle so a stale value never holds steady
    data_o <= (!zone_select_n_i && write_strobe_n_i) ? mem[addr_i[3:0]] : ~data_o;
  end
endmodule

// ### dv/tb_ebw_ctrl.sv
// self-checking bench: register port, reads and writes with and without ready waits
`timescale 1ns/1ns
module tb_ebw_ctrl
  import ebw_pkg::*;
;
  logic              clk_sys_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [3:0]        reg_addr_i = 4'h0;
  logic [31:0]       reg_wdata_i = 32'h0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [31:0]       reg_rdata_o, v;
  logic              req_valid_i = 1'b0;
  logic              req_rnw_i = 1'b1;
  logic [EBW_AW-1:0] req_addr_i = '0;
  logic [EBW_DW-1:0] req_wdata_i = '0;
  logic              req_ready_o, done_o, bclk, zs_n, rs_n, ws_n, rnw_o, oe, rdy, pz;
  logic [EBW_DW-1:0] rdata_o, data_i, data_o;
  logic [EBW_AW-1:0] addr_o, pa;
  logic [7:0]        hold = 8'hFF;
  int                bad_count = 0;
  int                n_compared = 0;

  initial forever #10 clk_sys_i = ~clk_sys_i;

  ebw_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i),
    .req_rnw_i(req_rnw_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .done_o(done_o), .rdata_o(rdata_o), .bus_clock_output_o(bclk), .zone_select_n_o(zs_n),
    .read_strobe_n_o(rs_n), .write_strobe_n_o(ws_n), .read_not_write_o(rnw_o), .addr_o(addr_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(oe), .external_wait_input_i(rdy));
  ebw_mem_model u_mem (.clk_sys_i(clk_sys_i), .zone_select_n_i(zs_n), .write_strobe_n_i(ws_n),
    .addr_i(addr_o), .data_i(data_o), .hold_cycles_i(hold), .data_o(data_i), .ready_o(rdy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
    @(posedge clk_sys_i);
    #1;
    chk(reg_rdata_o, 32'h0);
  endtask
  function automatic logic [31:0] tim(input logic en, input logic md, input logic dbl);
    return {5'h00, dbl, md, en, 24'h13_2132};
  endfunction
  // lead 2, active 3, trail 1 on both directions: zone select low for 6 cycles without waits
  task automatic access(input logic rnw, input logic [3:0] a, input logic [15:0] wd, input logic [7:0] h,
                        input int lo, input int hi, input logic [15:0] exp);
    int  len;
    logic pb;
    len  = 0;
    @(posedge clk_sys_i);
    hold        <= h;
    req_valid_i <= 1'b1;
    req_rnw_i   <= rnw;
    req_addr_i  <= {15'h0000, a};
    req_wdata_i <= wd;
    #1;
    pb = bclk;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      #1;
      if (!zs_n) begin
        if (len == 0) chk({31'h0, bclk & ~pb}, 32'h1);
        chk({31'h0, req_ready_o}, 32'h0);
        len++;
      end
      if (done_o === 1'b1) break;
      pb = bclk;
      @(posedge clk_sys_i);
    end
    chk({30'h0, done_o, req_ready_o}, 32'h3);
    n_compared++;
    if (len < lo || len > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t len=%h lo=%h", $time, len, lo);
    end
    if (rnw) chk({16'h0, rdata_o}, {16'h0, exp});
  endtask
  task automatic wrap_up;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // idle bus: address held, no strobe outside a selected zone
  always @(negedge clk_sys_i) begin
    if (!rst_i && zs_n && pz && addr_o !== pa) chk({13'h0, addr_o}, {13'h0, pa});
    if (!rst_i && zs_n) chk({29'h0, oe, rs_n, ws_n}, 32'h3);
    if (!rst_i && !ws_n) chk({30'h0, oe, rnw_o}, 32'h2);
    if (!rst_i && !rs_n) chk({30'h0, oe, rnw_o}, 32'h1);
    pz <= zs_n;
    pa <= addr_o;
  end

  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_rd(EBW_REG_TIMING);
    chk(v, EBW_TIMING_RST);
    reg_rd(4'h8);
    chk(v, 32'h0);
    reg_wr(EBW_REG_TIMING, tim(1'b0, 1'b0, 1'b0));
    reg_rd(EBW_REG_TIMING);
    chk(v, 32'h0013_2132);
    access(1'b1, 4'h3, 16'h0, 8'hFF, 6, 6, 16'hA503);
    access(1'b0, 4'h5, 16'h1234, 8'hFF, 6, 6, 16'h0);
    access(1'b1, 4'h5, 16'h0, 8'hFF, 6, 6, 16'h1234);
    reg_rd(EBW_REG_STATUS);
    chk(v & 32'hF, 32'h0);
    for (int m = 0; m < 2; m++) begin
      reg_wr(EBW_REG_TIMING, tim(1'b1, m[0], 1'b0));
      access(1'b1, 4'h3, 16'h0, 8'h00, 6, 6, 16'hA503);
      access(1'b1, 4'h7, 16'h0, 8'h09, 10, 14, 16'hA507);
      access(1'b0, 4'h9, 16'hBEEF, 8'h09, 10, 14, 16'h0);
      access(1'b1, 4'h9, 16'h0, 8'h00, 6, 6, 16'hBEEF);
    end
    reg_wr(EBW_REG_TIMING, tim(1'b0, 1'b0, 1'b1));
    access(1'b1, 4'h3, 16'h0, 8'hFF, 6, 6, 16'hA503);
    wrap_up();
  end
endmodule

// ### logic/ebw_ctrl.sv
// module: external bus access sequencer with ready-extended wait states
// Notes on behaviour
// - Every access lead period starts on a rising bus clock edge, with alignment cycles inserted if needed (up to three in double mode).
// - During an alignment cycle all strobes and the zone select are inactive.
// - On inactive and alignment cycles the address bus keeps the last address put out.
// - With ready in use, a high sample finishes the access and a low one repeats the sample every cycle.
// - Synchronous read: first sample at read lead plus read active cycles, then one per cycle.
// - Asynchronous read: first sample two cycles earlier than read lead plus read active.
// - Synchronous write: first sample at write lead plus write active cycles, then one per cycle.
// - Asynchronous write: first sample two cycles earlier than write lead plus write active.
// - With ready use cleared the ready input is ignored and only lead, active and trail counts time the access.
// - Lead and active periods are counted in timing clock cycles and place the sample points.
`timescale 1ns/1ns
module ebw_ctrl
  import ebw_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // access request port
  input  wire logic              req_valid_i,
  input  wire logic              req_rnw_i,
  input  wire logic [EBW_AW-1:0] req_addr_i,
  input  wire logic [EBW_DW-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic      [EBW_DW-1:0] rdata_o,
  // external bus pins
  output logic                   bus_clock_output_o,
  output logic                   zone_select_n_o,
  output logic                   read_strobe_n_o,
  output logic                   write_strobe_n_o,
  output logic                   read_not_write_o,
  output logic      [EBW_AW-1:0] addr_o,
  input  wire logic [EBW_DW-1:0] data_i,
  output logic      [EBW_DW-1:0] data_o,
  output logic                   data_oe_o,
  input  wire logic              external_wait_input_i
);

  typedef struct packed {
    ebw_state_t        state;
    logic [1:0]        div;
    logic              bclk;
    logic [EBW_EW-1:0] elapsed;
    logic [EBW_FW-1:0] trail_cnt;
    logic              rnw;
    logic [EBW_AW-1:0] addr;
    logic [EBW_AW-1:0] pend_addr;
    logic [EBW_DW-1:0] wdata;
    logic [EBW_DW-1:0] rdata;
    logic              rdy_seen;
    logic              done;
    logic              rdy_s1;
    logic              rdy_s2;
    logic [EBW_DW-1:0] dat_s1;
    logic [EBW_DW-1:0] dat_s2;
    logic [31:0]       timing;
    logic [31:0]       rdval;
    logic              zcs_n;
    logic              rd_n;
    logic              we_n;
    logic              oe;
  } ebw_st_t;

  ebw_st_t st_r;
  ebw_st_t st_nxt;

  // decoded timing fields for the access in flight
  logic [EBW_FW-1:0] lead_f;
  logic [EBW_FW-1:0] act_f;
  logic [EBW_FW-1:0] trail_f;
  logic              wait_en;
  logic              wait_async;
  logic              dbl;
  logic [EBW_EW-1:0] lead_end;
  logic [EBW_EW-1:0] act_end;
  logic [EBW_EW-1:0] sample_pt;
  logic [EBW_EW-1:0] elapsed_p1;
  logic              sampling;
  logic              act_reached;
  logic              rdy_ok;
  logic              rise_next;
  logic [1:0]        div_next;

  always_comb begin
    lead_f     = st_r.rnw ? st_r.timing[EBW_F_RD_LEAD +: EBW_FW] : st_r.timing[EBW_F_WR_LEAD +: EBW_FW];
    act_f      = st_r.rnw ? st_r.timing[EBW_F_RD_ACTIVE +: EBW_FW] : st_r.timing[EBW_F_WR_ACTIVE +: EBW_FW];
    trail_f    = st_r.rnw ? st_r.timing[EBW_F_RD_TRAIL +: EBW_FW] : st_r.timing[EBW_F_WR_TRAIL +: EBW_FW];
    wait_en    = st_r.timing[EBW_F_WAIT_EN];
    wait_async = st_r.timing[EBW_F_WAIT_MODE];
    dbl        = st_r.timing[EBW_F_DOUBLE];
    // a lead of zero still needs one cycle so the select can lead the strobe
    lead_end   = (lead_f == '0) ? EBW_ONE : {4'h0, lead_f};
    act_end    = lead_end + {4'h0, act_f};
    // early sampling compensates for the two-flop synchroniser on the pin
    if (wait_async && act_end > EBW_ASYNC_ADV) begin
      sample_pt = act_end - EBW_ASYNC_ADV;
    end else if (wait_async) begin
      sample_pt = EBW_ONE;
    end else begin
      sample_pt = act_end;
    end
    elapsed_p1  = st_r.elapsed + EBW_ONE;
    sampling    = wait_en && (st_r.state == EBW_LEAD || st_r.state == EBW_ACTIVE)
                  && (elapsed_p1 >= sample_pt);
    act_reached = (st_r.state == EBW_ACTIVE) && (elapsed_p1 >= act_end);
    // ready input ignored entirely when waits are off
    rdy_ok      = !wait_en || st_r.rdy_seen || (sampling && st_r.rdy_s2);
    div_next    = st_r.div + 2'h1;
    rise_next   = dbl ? (div_next[1] && !st_r.div[1]) : (div_next[0] && !st_r.div[0]);
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.rdy_s1 = external_wait_input_i;
    st_nxt.rdy_s2 = st_r.rdy_s1;
    st_nxt.dat_s1 = data_i;
    st_nxt.dat_s2 = st_r.dat_s1;
    st_nxt.div    = div_next;
    st_nxt.bclk   = dbl ? div_next[1] : div_next[0];
    st_nxt.rdval  = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        EBW_REG_TIMING: st_nxt.rdval = st_r.timing;
        EBW_REG_STATUS: st_nxt.rdval = {26'h0, st_r.rdy_seen, sampling, (st_r.state != EBW_IDLE), st_r.state};
        default:        st_nxt.rdval = 32'h0000_0000;
      endcase
    end
    // timing is only reloaded when idle so an access never sees a mixed setting
    if (reg_wr_i && reg_addr_i == EBW_REG_TIMING && st_r.state == EBW_IDLE) begin
      st_nxt.timing = reg_wdata_i;
    end
    if (sampling && st_r.rdy_s2) begin
      st_nxt.rdy_seen = 1'b1;
    end
    st_nxt.elapsed = elapsed_p1;
    case (st_r.state)
      EBW_IDLE: begin
        st_nxt.elapsed  = '0;
        st_nxt.rdy_seen = 1'b0;
        if (req_valid_i) begin
          st_nxt.rnw       = req_rnw_i;
          st_nxt.wdata     = req_wdata_i;
          st_nxt.pend_addr = req_addr_i;
          if (rise_next) begin
            st_nxt.state = EBW_LEAD;
            st_nxt.addr  = req_addr_i;
          end else begin
            // the pins keep the old address until the aligned lead starts
            st_nxt.state = EBW_ALIGN;
          end
        end
      end
      EBW_ALIGN: begin
        st_nxt.elapsed = '0;
        if (rise_next) begin
          st_nxt.state = EBW_LEAD;
          st_nxt.addr  = st_r.pend_addr;
        end
      end
      EBW_LEAD: begin
        if (elapsed_p1 >= lead_end) begin
          st_nxt.state = EBW_ACTIVE;
        end
      end
      EBW_ACTIVE: begin
        if (act_reached && rdy_ok) begin
          st_nxt.rdata     = st_r.dat_s2;
          st_nxt.trail_cnt = trail_f;
          if (trail_f == '0) begin
            st_nxt.state = EBW_IDLE;
            st_nxt.done  = 1'b1;
          end else begin
            st_nxt.state = EBW_TRAIL;
          end
        end
      end
      EBW_TRAIL: begin
        st_nxt.trail_cnt = st_r.trail_cnt - 4'h1;
        if (st_r.trail_cnt == 4'h1) begin
          st_nxt.state = EBW_IDLE;
          st_nxt.done  = 1'b1;
        end
      end
      default: st_nxt.state = EBW_IDLE;
    endcase
    // pin levels follow the next state; alignment and idle are fully inactive
    st_nxt.zcs_n = !(st_nxt.state == EBW_LEAD || st_nxt.state == EBW_ACTIVE || st_nxt.state == EBW_TRAIL);
    st_nxt.rd_n  = !(st_nxt.state == EBW_ACTIVE && st_nxt.rnw);
    st_nxt.we_n  = !(st_nxt.state == EBW_ACTIVE && !st_nxt.rnw);
    st_nxt.oe    = !st_nxt.rnw && (st_nxt.state == EBW_ACTIVE || st_nxt.state == EBW_TRAIL);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.state    <= EBW_IDLE;
      st_r.timing   <= EBW_TIMING_RST;
      st_r.rnw      <= 1'b1;
      st_r.zcs_n    <= 1'b1;
      st_r.rd_n     <= 1'b1;
      st_r.we_n     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o        = st_r.rdval;
  assign req_ready_o        = (st_r.state == EBW_IDLE);
  assign done_o             = st_r.done;
  assign rdata_o            = st_r.rdata;
  assign bus_clock_output_o = st_r.bclk;
  assign zone_select_n_o    = st_r.zcs_n;
  assign read_strobe_n_o    = st_r.rd_n;
  assign write_strobe_n_o   = st_r.we_n;
  assign read_not_write_o   = st_r.rnw;
  assign addr_o             = st_r.addr;
  assign data_o             = st_r.wdata;
  assign data_oe_o          = st_r.oe;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_lead_entry;
    (st_r.state != EBW_LEAD) ##1 (st_r.state == EBW_LEAD);
  endsequence

  a_lead_on_rise: assert property (s_lead_entry |-> $rose(st_r.bclk))
    else $error("lead period began off a rising bus clock edge");
  a_align_quiet: assert property ((st_r.state == EBW_ALIGN) |-> (zone_select_n_o && read_strobe_n_o
    && write_strobe_n_o))
    else $error("strobe active during alignment cycle");
  a_addr_hold: assert property ((st_r.state == EBW_IDLE || st_r.state == EBW_ALIGN) ##1
    (st_r.state != EBW_LEAD) |-> $stable(addr_o))
    else $error("address changed on inactive cycle");
  a_ready_finish: assert property ((act_reached && sampling && st_r.rdy_s2) |=> (st_r.state != EBW_ACTIVE))
    else $error("access did not finish on high ready sample");
  a_ready_stall: assert property ((act_reached && wait_en && !st_r.rdy_seen && !(sampling && st_r.rdy_s2))
    |=> (st_r.state == EBW_ACTIVE))
    else $error("access finished without ready");
  a_sync_point: assert property ((sampling && !wait_async) |-> (elapsed_p1 >= act_end))
    else $error("synchronous ready sampled too early");
  a_async_point: assert property ((wait_async && wait_en && st_r.state == EBW_ACTIVE && act_end > EBW_ASYNC_ADV
    && elapsed_p1 == act_end - EBW_ASYNC_ADV) |-> sampling)
    else $error("asynchronous ready not sampled two cycles early");
  a_ready_ignored: assert property ((!wait_en && act_reached) |=> (st_r.state != EBW_ACTIVE))
    else $error("ready input affected access with waits off");
  a_lead_count: assert property ((st_r.state == EBW_LEAD) |-> (st_r.elapsed < lead_end))
    else $error("lead period overran its count");
  a_wait_hold: assert property ((st_r.state == EBW_ACTIVE) |-> (!zone_select_n_o
    && (read_strobe_n_o != write_strobe_n_o)))
    else $error("strobes dropped while active");

endmodule

// ### logic/ebw_pkg.sv
// package: constants, register map and state types of the external bus wait control
package ebw_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [3:0]  EBW_REG_TIMING  = 4'h0;
  localparam logic [3:0]  EBW_REG_STATUS  = 4'h4;
  localparam logic [31:0] EBW_TIMING_RST  = 32'h0000_0000;
  // timing register field positions
  localparam int EBW_F_RD_LEAD   = 0;
  localparam int EBW_F_RD_ACTIVE = 4;
  localparam int EBW_F_RD_TRAIL  = 8;
  localparam int EBW_F_WR_LEAD   = 12;
  localparam int EBW_F_WR_ACTIVE = 16;
  localparam int EBW_F_WR_TRAIL  = 20;
  localparam int EBW_F_WAIT_EN   = 24;
  localparam int EBW_F_WAIT_MODE = 25;
  localparam int EBW_F_DOUBLE    = 26;
  localparam int EBW_FW          = 4;
  // widths
  localparam int EBW_AW = 19;
  localparam int EBW_DW = 16;
  localparam int EBW_EW = 8;
  // asynchronous sampling starts this many timing cycles early
  localparam logic [EBW_EW-1:0] EBW_ASYNC_ADV = 8'h02;
  localparam logic [EBW_EW-1:0] EBW_ONE       = 8'h01;

  typedef enum logic [2:0] {
    EBW_IDLE,
    EBW_ALIGN,
    EBW_LEAD,
    EBW_ACTIVE,
    EBW_TRAIL
  } ebw_state_t;
endpackage
